// ===== lsf_bus_node.sv
// model of another node and the pull-up on the single-wire link
`timescale 1ns/10ps

// ============================================================================
// far node model
// ============================================================================
module lsf_bus_node (
  // device pin
  input  wire logic dev_drive,
  input  wire logic dev_enable,
  // commanded dominant drive of the far node
  input  wire logic node_dom,
  // resolved wire level
  output logic      bus
);
  // wired-and: any dominant driver pulls low, the pull-up gives recessive high
  assign bus = !node_dom && !(dev_enable && !dev_drive);
endmodule

// ===== lsf_pkg.sv
// package: register indices, bit positions and timing constants of the link status block
package lsf_pkg;

  // ==========================================================================
  // indirect register indices
  // ==========================================================================
  localparam logic [3:0] REG_LINK_CONTROL      = 4'h8;  // control register index
  localparam logic [3:0] REG_LINK_STATUS       = 4'h9;  // status register index
  localparam logic [3:0] REG_LINK_ERROR_CAUSE  = 4'ha;  // error cause register index

  // ==========================================================================
  // control bit positions
  // ==========================================================================
  localparam int CTL_STOP   = 7;  // halt until next break (slave)
  localparam int CTL_DATA_ACKNOWLEDGE_CONTROL  = 4;  // data acknowledge (slave)
  localparam int CTL_INTERRUPT_RESET_CONTROL = 3;  // interrupt reset
  localparam int CTL_ERROR_RESET_CONTROL = 2;  // error reset

  // ==========================================================================
  // status bit positions
  // ==========================================================================
  localparam int ST_ACTIVE = 7;
  localparam int ST_IDLE_TIMEOUT_FLAG   = 6;
  localparam int ST_ABORT  = 5;
  localparam int ST_DATA_REQUEST_FLAG  = 4;
  localparam int ST_INTERRUPT_PENDING_FLAG = 3;
  localparam int ST_ERROR  = 2;
  localparam int ST_WAKEUP = 1;
  localparam int ST_DONE   = 0;

  // ==========================================================================
  // error cause bit positions
  // ==========================================================================
  localparam int ER_SYNC  = 4;
  localparam int ER_PARITY_ERROR  = 3;
  localparam int ER_TIMEOUT_ERROR  = 2;
  localparam int ER_CHK   = 1;
  localparam int ER_BIT   = 0;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam longint CLK_HZ          = 100000000;  // system clock rate
  localparam longint IDLE_TIMEOUT_S  = 4;          // bus idle timeout in seconds
  localparam longint IDLE_CYCLES     = IDLE_TIMEOUT_S * CLK_HZ;
  localparam int     QUIET_CYCLES    = 16;         // rx-level stable time counted as no activity

  // ==========================================================================
  // event carrier from the protocol engine
  // ==========================================================================
  typedef struct packed {
    logic frame_start;    // transmission of a frame begins
    logic frame_end;      // current frame finished
    logic break_seen;     // break field detected
    logic id_received;    // protected identifier received
    logic sync_bad;       // sync field edge out of tolerance
    logic parity_bad;     // identifier parity check failed
    logic no_response;    // master saw no slave response
    logic no_data;        // slave saw no data when expected
    logic frame_overrun;  // frame longer than the maximum length
    logic first_byte_end; // first byte after identifier fully received
    logic checksum_bad;   // received checksum mismatch
    logic wake_tx;        // wakeup being transmitted
    logic wake_rx;        // wakeup received
    logic irq_event;      // controller interrupt raised
    logic sleep_entered;  // bus now in sleep
  } lsf_evt_s;

endpackage

// ===== lsf_status_error_flags.sv
// status and error flag logic of a single-wire link controller
`timescale 1ns/10ps

module lsf_status_error_flags
  import lsf_pkg::*;
#(
  parameter longint IDLE_LIMIT = IDLE_CYCLES  // cycles of silence before idle flag
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // mode
  input  wire logic        master_mode,
  // link pin readback and drive
  input  wire logic        link_rx,
  input  wire logic        link_tx_drive,
  input  wire logic        link_tx_enable,
  // protocol engine events
  input  wire lsf_evt_s    evt,
  // indirect register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // control bits for the protocol engine
  output logic             halt_active,
  output logic             data_ack
);

  // ==========================================================================
  // pin synchroniser
  // ==========================================================================
  logic       rx_m1;   // first stage, read by second only
  logic       rx_m2;   // second stage
  logic       rx_m3;   // third stage
  logic       rx_lvl;  // accepted level

  // three stage sampler of the bus pin
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_m1  <= 1'b1;
      rx_m2  <= 1'b1;
      rx_m3  <= 1'b1;
      rx_lvl <= 1'b1;
    end else begin
      rx_m1 <= link_rx;
      rx_m2 <= rx_m1;
      rx_m3 <= rx_m2;
      if (rx_m2 == rx_m3) begin
        rx_lvl <= rx_m3;
      end
    end
  end

  // ==========================================================================
  // activity detection and idle timeout
  // ==========================================================================
  logic        rx_prev;     // last accepted level
  logic        rx_edge;     // accepted level changed
  logic [4:0]  quiet_cnt;   // short quiet counter
  logic [31:0] idle_cnt;    // long silence counter
  logic        active_flag;
  logic        idle_flag;
  logic        asleep;      // bus asleep, held until activity returns

  assign rx_edge = (rx_lvl != rx_prev);

  // previous level register
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= rx_lvl;
    end
  end

  // activity bit: set on edge or dominant level, cleared after quiet time
  always_ff @(posedge clk) begin
    if (srst) begin
      quiet_cnt   <= 5'h00;
      active_flag <= 1'b0;
    end else if (rx_edge || !rx_lvl) begin
      quiet_cnt   <= 5'h00;
      active_flag <= 1'b1;
    end else if (quiet_cnt < 5'(QUIET_CYCLES)) begin
      quiet_cnt <= quiet_cnt + 5'h01;
    end else begin
      active_flag <= 1'b0;
    end
  end

  // sleep latch: a one-cycle sleep pulse alone would let the idle count restart
  always_ff @(posedge clk) begin
    if (srst) begin
      asleep <= 1'b0;
    end else if (evt.sleep_entered) begin
      asleep <= 1'b1;
    end else if (active_flag) begin
      asleep <= 1'b0;
    end
  end

  // idle flag: slave only, silence for the limit, not yet asleep
  always_ff @(posedge clk) begin
    if (srst) begin
      idle_cnt  <= 32'h0;
      idle_flag <= 1'b0;
    end else if (master_mode || active_flag || asleep || evt.sleep_entered) begin
      idle_cnt  <= 32'h0;
      idle_flag <= 1'b0;
    end else if (idle_cnt < 32'(IDLE_LIMIT - 1)) begin
      idle_cnt <= idle_cnt + 32'h1;
    end else begin
      idle_flag <= 1'b1;
    end
  end

  // ==========================================================================
  // control register writes
  // ==========================================================================
  logic ctl_wr;     // write to control register
  logic rst_int;    // interrupt reset strobe
  logic rst_err;    // error reset strobe
  logic stop_req;   // halt request strobe

  assign ctl_wr   = reg_wr && (reg_addr == REG_LINK_CONTROL);
  assign rst_int  = ctl_wr && reg_wdata[CTL_INTERRUPT_RESET_CONTROL];
  assign rst_err  = ctl_wr && reg_wdata[CTL_ERROR_RESET_CONTROL];
  assign stop_req = ctl_wr && reg_wdata[CTL_STOP] && !master_mode;

  // halt state held until next break
  always_ff @(posedge clk) begin
    if (srst) begin
      halt_active <= 1'b0;
    end else if (stop_req) begin
      halt_active <= 1'b1;
    end else if (evt.break_seen) begin
      halt_active <= 1'b0;
    end
  end

  // acknowledge bit, cleared by the controller when frame ends or a break is seen
  always_ff @(posedge clk) begin
    if (srst) begin
      data_ack <= 1'b0;
    end else if (ctl_wr && reg_wdata[CTL_DATA_ACKNOWLEDGE_CONTROL] && !master_mode) begin
      data_ack <= 1'b1;
    end else if (evt.frame_end || evt.break_seen) begin
      data_ack <= 1'b0;
    end
  end

  // ==========================================================================
  // frame tracking and status flags
  // ==========================================================================
  logic in_frame;     // a frame is under way
  logic abort_flag;
  logic dreq_flag;
  logic int_flag;
  logic wake_flag;
  logic done_flag;
  logic wake_rx_seen; // wakeup received and remembered

  // frame in progress tracker
  always_ff @(posedge clk) begin
    if (srst) begin
      in_frame <= 1'b0;
    end else if (evt.break_seen || evt.frame_start) begin
      in_frame <= 1'b1;
    end else if (evt.frame_end) begin
      in_frame <= 1'b0;
    end
  end

  // abort flag: set wins over clean-break clear
  always_ff @(posedge clk) begin
    if (srst) begin
      abort_flag <= 1'b0;
    end else if (!master_mode && (stop_req || (evt.break_seen && in_frame))) begin
      abort_flag <= 1'b1;
    end else if (evt.break_seen) begin
      abort_flag <= 1'b0;
    end
  end

  // data request flag: set on identifier, cleared by acknowledge, halt or new frame
  always_ff @(posedge clk) begin
    if (srst) begin
      dreq_flag <= 1'b0;
    end else if (!master_mode && evt.id_received) begin
      dreq_flag <= 1'b1;
    end else if (evt.break_seen || data_ack || halt_active) begin
      dreq_flag <= 1'b0;
    end
  end

  // interrupt pending flag: set wins over reset
  always_ff @(posedge clk) begin
    if (srst) begin
      int_flag <= 1'b0;
    end else if (evt.irq_event) begin
      int_flag <= 1'b1;
    end else if (rst_int) begin
      int_flag <= 1'b0;
    end
  end

  // wake flag: live while sending, latched when received
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_rx_seen <= 1'b0;
    end else if (evt.wake_rx) begin
      wake_rx_seen <= 1'b1;
    end else if (evt.break_seen) begin
      wake_rx_seen <= 1'b0;
    end
  end

  // registered wake bit
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_flag <= 1'b0;
    end else begin
      wake_flag <= evt.wake_tx || evt.wake_rx || wake_rx_seen;
    end
  end

  // done flag: end wins over start in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      done_flag <= 1'b0;
    end else if (evt.frame_end) begin
      done_flag <= 1'b1;
    end else if (evt.frame_start) begin
      done_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // error flags
  // ==========================================================================
  logic       ack_window;   // waiting for acknowledge after identifier
  logic       timeout_error_hit;     // any timeout cause this cycle
  logic       bit_mismatch; // readback differs from drive
  logic [4:0] err_set;      // per-cause set strobes
  logic [4:0] err_flags;    // sticky error causes
  logic       err_summary;

  // acknowledge window opens on identifier, closes on acknowledge, halt, break or frame end
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_window <= 1'b0;
    end else if (!master_mode && evt.id_received) begin
      ack_window <= 1'b1;
    end else if (data_ack || halt_active || evt.break_seen || evt.frame_end) begin
      ack_window <= 1'b0;
    end
  end

  assign timeout_error_hit = (master_mode && evt.no_response)
                 || (!master_mode && evt.no_data)
                 || evt.frame_overrun
                 || (ack_window && evt.first_byte_end && !data_ack
                     && !halt_active);

  // compare against the synchronised level while driving
  assign bit_mismatch = link_tx_enable && rx_edge && (rx_lvl != link_tx_drive);

  assign err_set[ER_SYNC] = !master_mode && evt.sync_bad;
  assign err_set[ER_PARITY_ERROR] = !master_mode && evt.parity_bad;
  assign err_set[ER_TIMEOUT_ERROR] = timeout_error_hit;
  assign err_set[ER_CHK]  = evt.checksum_bad;
  assign err_set[ER_BIT]  = bit_mismatch;

  // one sticky bit per cause, set wins over reset
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_err
      always_ff @(posedge clk) begin
        if (srst) begin
          err_flags[gi] <= 1'b0;
        end else if (err_set[gi]) begin
          err_flags[gi] <= 1'b1;
        end else if (rst_err) begin
          err_flags[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // summary error flag
  always_ff @(posedge clk) begin
    if (srst) begin
      err_summary <= 1'b0;
    end else if (|err_set) begin
      err_summary <= 1'b1;
    end else if (rst_err) begin
      err_summary <= 1'b0;
    end
  end

  // ==========================================================================
  // register read port
  // ==========================================================================
  // registered read data; control reads its self-clearing bits as zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_LINK_STATUS: begin
          reg_rdata <= {active_flag, idle_flag, abort_flag, dreq_flag,
                        int_flag, err_summary, wake_flag, done_flag};
        end
        REG_LINK_ERROR_CAUSE: begin
          reg_rdata <= {3'h0, err_flags};
        end
        REG_LINK_CONTROL: begin
          reg_rdata <= {3'h0, data_ack, 4'h0};
        end
        default: begin
          reg_rdata <= 8'h00;
        end
      endcase
    end
  end

endmodule

// ===== lsf_status_error_flags_assertions.sv
// checker of the link status block, bound to its ports
`timescale 1ns/10ps

// ============================================================================
// port checker
// ============================================================================
module lsf_sef_chk
  import lsf_pkg::*;
#(
  parameter longint IDLE_LIMIT = IDLE_CYCLES  // mirrors the design parameter
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // mode and pin
  input wire logic       master_mode,
  input wire logic       link_rx,
  input wire logic       link_tx_drive,
  input wire logic       link_tx_enable,
  // engine events
  input wire lsf_evt_s   evt,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // control outputs
  input wire logic       halt_active,
  input wire logic       data_ack
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic ctl_wr;   // control register write
  logic err_evt;  // anything that may raise an error this cycle
  logic sl_wr;    // control write in slave mode
  assign ctl_wr = reg_wr && (reg_addr == REG_LINK_CONTROL);
  assign sl_wr = ctl_wr && !master_mode;
  assign err_evt = evt.sync_bad | evt.parity_bad | evt.no_response | evt.no_data | evt.frame_overrun
                   | evt.first_byte_end | evt.checksum_bad | link_tx_enable;
  a_ack_set: assert property (sl_wr && reg_wdata[CTL_DATA_ACKNOWLEDGE_CONTROL] && !evt.frame_end && !evt.break_seen
    |=> data_ack)
    else $error("acknowledge not set");
  a_ack_clear: assert property (data_ack && (evt.frame_end || evt.break_seen) && !ctl_wr |=> !data_ack)
    else $error("acknowledge not cleared");
  a_ack_master: assert property (master_mode && !data_ack |=> !data_ack)
    else $error("acknowledge set in master mode");
  a_halt_set: assert property (sl_wr && reg_wdata[CTL_STOP] && !evt.break_seen |=> halt_active)
    else $error("halt not set");
  a_halt_clear: assert property (halt_active && evt.break_seen && !ctl_wr |=> !halt_active)
    else $error("halt not cleared by break");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_err_upper: assert property (reg_rd && reg_addr == REG_LINK_ERROR_CAUSE |=> reg_rdata[7:5] == 3'h0)
    else $error("error upper bits not zero");
  a_ctl_read: assert property (reg_rd && reg_addr == REG_LINK_CONTROL
    |=> reg_rdata == {3'h0, $past(data_ack), 4'h0})
    else $error("control read wrong");
  a_err_reset: assert property (ctl_wr && reg_wdata[CTL_ERROR_RESET_CONTROL] && !err_evt ##1 !err_evt
    ##1 reg_rd && reg_addr == REG_LINK_ERROR_CAUSE |=> reg_rdata == 8'h00)
    else $error("errors survive error reset");
  c_err_reset: cover property (ctl_wr && reg_wdata[CTL_ERROR_RESET_CONTROL]);
  c_ack_cycle: cover property (data_ack ##1 !data_ack);
  c_halt_cycle: cover property (halt_active ##1 !halt_active);
endmodule

bind lsf_status_error_flags lsf_sef_chk #(.IDLE_LIMIT(IDLE_LIMIT)) chk_u (.clk(clk), .srst(srst),
  .master_mode(master_mode), .link_rx(link_rx), .link_tx_drive(link_tx_drive), .link_tx_enable(link_tx_enable),
  .evt(evt), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .halt_active(halt_active), .data_ack(data_ack));

// ===== lsf_status_error_flags_test.sv
// self-checking bench of the link status block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module lsf_status_error_flags_test;
  import lsf_pkg::*;
  localparam longint IDLE_SIM = 1000;  // shortened idle limit
  // ==========================================================================
  // stimulus, outputs and model state
  // ==========================================================================
  logic       clk = 1'b0, srst = 1'b1, master_mode = 1'b0, node_dom = 1'b0;
  logic       link_tx_drive = 1'b1, link_tx_enable = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, st = 8'h00, er = 8'h00;
  logic       link_rx, halt_active, data_ack;
  logic       inf = 1'b0, ack = 1'b0, halt = 1'b0, idw = 1'b0;  // model: in frame, ack, halt, ack window
  lsf_evt_s   evt = '0;
  int         n_errors = 0, num_checks = 0, i;
  int         ek[6] = '{10, 9, 7, 6, 4, 8};  // slave error events, last one ignored in slave mode
  always #5 clk = ~clk;
  lsf_bus_node node_u (.dev_drive(link_tx_drive), .dev_enable(link_tx_enable), .node_dom(node_dom), .bus(link_rx));
  lsf_status_error_flags #(.IDLE_LIMIT(IDLE_SIM)) dut_u (.clk(clk), .srst(srst), .master_mode(master_mode),
    .link_rx(link_rx), .link_tx_drive(link_tx_drive), .link_tx_enable(link_tx_enable), .evt(evt),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_active(halt_active), .data_ack(data_ack));
  // ==========================================================================
  // bus tasks with the behavioural model
  // ==========================================================================
  // one engine event pulse, then the model update
  task fire(input int k);
    begin
      @(posedge clk) evt <= lsf_evt_s'(15'h1 << k);
      @(posedge clk) evt <= '0;
      case (k)
        14: begin st[0] = 1'b0; inf = 1'b1; end
        13: begin st[0] = 1'b1; inf = 1'b0; ack = 1'b0; idw = 1'b0; end
        12: begin st[5] = !master_mode && inf; inf = 1'b1; st[1] = 1'b0; st[4] = 1'b0;
          ack = 1'b0; halt = 1'b0; idw = 1'b0; end
        11: if (!master_mode) begin st[4] = 1'b1; idw = 1'b1; end
        10, 9: if (!master_mode) er[k - 6] = 1'b1;
        8: if (master_mode) er[2] = 1'b1;
        7: if (!master_mode) er[2] = 1'b1;
        6: er[2] = 1'b1;
        5: begin if (idw && !ack && !halt) er[2] = 1'b1; idw = 1'b0; end
        4: er[1] = 1'b1;
        2: st[1] = 1'b1;
        1: st[3] = 1'b1;
        0: st[6] = 1'b0;
        default: ;
      endcase
      if (er != 8'h00) st[2] = 1'b1;
    end
  endtask
  // register write, control bits modelled
  task wr(input logic [3:0] a, input logic [7:0] d);
    begin
      @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
      @(posedge clk) reg_wr <= 1'b0;
      if (a == REG_LINK_CONTROL) begin
        if (d[CTL_ERROR_RESET_CONTROL]) begin er = 8'h00; st[2] = 1'b0; end
        if (d[CTL_INTERRUPT_RESET_CONTROL]) st[3] = 1'b0;
        if (!master_mode && d[CTL_DATA_ACKNOWLEDGE_CONTROL]) begin ack = 1'b1; st[4] = 1'b0; idw = 1'b0; end
        if (!master_mode && d[CTL_STOP]) begin halt = 1'b1; st[5] = 1'b1; st[4] = 1'b0; idw = 1'b0; end
      end
    end
  endtask
  // register read compared with the model
  task rd(input logic [3:0] a);
    logic [7:0] e;
    begin
      e = (a == REG_LINK_STATUS) ? st : (a == REG_LINK_ERROR_CAUSE) ? er :
          (a == REG_LINK_CONTROL) ? {3'h0, ack, 4'h0} : 8'h00;
      @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
      @(posedge clk) reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
      `CHK({halt_active, data_ack}, {halt, ack})
    end
  endtask
  // verdict and end of run
  task finish_test;
    begin
      if (n_errors == 0 && num_checks > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial begin
    void'($urandom(57));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(4'h9); rd(4'ha); rd(4'h8);
    rd(4'(11 + $urandom_range(4)));
    wr(4'ha, 8'($urandom)); wr(4'h9, 8'($urandom)); rd(4'ha); rd(4'h9);
    repeat (IDLE_SIM - 100) @(posedge clk);
    rd(4'h9);
    repeat (100) @(posedge clk);
    st[6] = 1'b1; rd(4'h9);
    fire(0); rd(4'h9); repeat (IDLE_SIM) @(posedge clk); rd(4'h9);
    // far node pulls low while the device sends recessive
    @(posedge clk) begin link_tx_enable <= 1'b1; node_dom <= 1'b1; end
    repeat (8) @(posedge clk);
    st[7] = 1'b1; st[6] = 1'b0; er[0] = 1'b1; st[2] = 1'b1; rd(4'h9);
    @(posedge clk) begin link_tx_enable <= 1'b0; node_dom <= 1'b0; end
    repeat (QUIET_CYCLES + 10) @(posedge clk);
    st[7] = 1'b0; rd(4'h9); rd(4'ha);
    wr(4'h8, 8'h04); rd(4'ha); rd(4'h9); rd(4'h8);
    for (i = 0; i < $size(ek); i++) begin
      fire(ek[i]); rd(4'ha); rd(4'h9); rd(4'ha);
      wr(4'h8, 8'h04); rd(4'ha);
    end
    @(posedge clk) master_mode <= 1'b1;
    fire(10); fire(9); fire(11); fire(7); rd(4'ha);
    fire(8); rd(4'ha); rd(4'h9);
    wr(4'h8, 8'h94); rd(4'h8); rd(4'ha);
    @(posedge clk) master_mode <= 1'b0;
    fire(11); rd(4'h9); wr(4'h8, 8'h10); rd(4'h8); rd(4'h9);
    fire(5); rd(4'ha);
    fire(13); rd(4'h8); rd(4'h9); fire(14); rd(4'h9);
    fire(12); rd(4'h9); fire(13); fire(12); rd(4'h9);
    fire(11); fire(5); rd(4'ha); rd(4'h9);
    wr(4'h8, 8'h84); rd(4'h9); fire(12); rd(4'h9);
    fire(1); wr(4'h8, 8'h04); rd(4'h9); wr(4'h8, 8'h08); rd(4'h9);
    fire(2); rd(4'h9); fire(12); rd(4'h9);
    @(posedge clk) evt.wake_tx <= 1'b1;
    st[1] = 1'b1; rd(4'h9);
    @(posedge clk) evt.wake_tx <= 1'b0;
    repeat (2) @(posedge clk);
    st[1] = 1'b0; rd(4'h9);
    finish_test;
  end
  // watchdog against a hang
  initial begin
    #100000;
    n_errors++;
    finish_test;
  end
endmodule
